// >>> src/atpe_top.sv
// Test tone, per-pair arrangement and gain, and embedder control for eight pairs.
// Assumes smp_tick and mx_vld are one-cycle strobes from logic on clk.
// ------------------------------------------------------------------------
// Function
// R01: Stereo 1 kHz sine offered to matrix
// R02: Left silent 250 ms every 3 s
// R03: Tone level -18 or -20 dBFS
// R04: Each pair has own mode and gain
// R05: Eight modes; straight and swap
// R06: Left duplicate: both outputs carry left
// R07: Right duplicate: both outputs carry right
// R08: Invert left negates left only
// R09: Invert right negates right only
// R10: Mono sum: both carry (L+R)/2
// R11: Mid/side converts AB pair to MS
// R12: Summing modes attenuated by 6 dB
// R13: Gain in dB is setting/100
// R14: Gain range +-96 dB, 0.1 dB steps (code steps in 0.01 dB)
// R15: Non-audio data bypasses gain bit-exact
// R16: Disabled group's audio is removed
// R17: SD option truncates 24-bit to 20-bit
// R18: Truncation leaves control packet untouched
// R19: SD control packet only when enabled
// R20: Bypass leaves incoming audio unchanged
// R21: Eight pairs processed then re-embedded
// R22: Incoming audio always accepted, no disable
// R23: Mid left, side right, saturating
// R24: Gain saturates and rounds to nearest
// ------------------------------------------------------------------------
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "atpe_regs.svh"
module atpe_top
   import atpe_pkg::*;
#(
   parameter int TONE_PERIOD_CYC = `ATPE_PERIOD_MS * `ATPE_CLK_KHZ,
   parameter int TONE_GAP_CYC    = `ATPE_GAP_MS * `ATPE_CLK_KHZ
)
(
   // Clock, reset, enable
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic          ce,
   // Register port
   input  wire logic [7:0]    reg_addr,
   input  wire logic [31:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [31:0]   reg_rdata,
   // Tone source
   input  wire logic          smp_tick,
   output logic      [23:0]   tone_l_q,
   output logic      [23:0]   tone_r_q,
   // Matrix pairs in
   input  wire logic          mx_vld,
   input  wire logic [191:0]  mx_l,
   input  wire logic [191:0]  mx_r,
   input  wire logic [7:0]    mx_non_audio,
   // Embedder out
   output logic               emb_vld_q,
   output logic      [191:0]  emb_l_q,
   output logic      [191:0]  emb_r_q,
   output logic      [7:0]    emb_non_audio_q,
   output logic      [3:0]    grp_insert_q,
   output logic      [3:0]    grp_remove_q,
   output logic      [3:0]    acp_insert_q,
   output logic               emb_bypass_q
);
   localparam logic [31:0] PERIOD_LAST = 32'(TONE_PERIOD_CYC - 1);
   localparam logic [31:0] GAP_LAST    = 32'(TONE_GAP_CYC - 1);

   logic [2:0]    ctrl_q;
   logic [15:0]   emb_q;
   logic [23:0]   mode_q;
   logic [127:0]  gain_vec;
   logic [31:0]   rd_mux;
   logic [31:0]   gap_cnt_q;
   atpe_tone_st_t tone_st_q;
   logic [1:0]    quad_q;
   logic [3:0]    idx_q;
   logic [3:0]    lut_idx;
   logic [23:0]   amp;
   logic [47:0]   tprod;
   logic [23:0]   tmag;
   logic [23:0]   tone_val;
   logic          vld1_q;
   logic          vld2_q;
   logic          byp;
   logic          sd;

   assign byp = ctrl_q[`ATPE_CTRL_BYP];
   assign sd  = ctrl_q[`ATPE_CTRL_SD];

   function automatic logic [14:0] sine_q15(input logic [3:0] i);
      case (i)
         4'h0:    sine_q15 = 15'h0000;
         4'h1:    sine_q15 = 15'h10B5;
         4'h2:    sine_q15 = 15'h2121;
         4'h3:    sine_q15 = 15'h30FC;
         4'h4:    sine_q15 = 15'h4000;
         4'h5:    sine_q15 = 15'h4DEC;
         4'h6:    sine_q15 = 15'h5A82;
         4'h7:    sine_q15 = 15'h658D;
         4'h8:    sine_q15 = 15'h6EDA;
         4'h9:    sine_q15 = 15'h7642;
         4'hA:    sine_q15 = 15'h7BA3;
         4'hB:    sine_q15 = 15'h7EE8;
         default: sine_q15 = 15'h7FFF;
      endcase
   endfunction : sine_q15

   function automatic logic [23:0] neg_sat(input logic [23:0] x);
      neg_sat = (x == `ATPE_SMP_MIN) ? `ATPE_SMP_MAX : 24'(-x);
   endfunction : neg_sat

   function automatic logic [47:0] arrange(input atpe_mode_t m,
                                           input logic [23:0] l,
                                           input logic [23:0] r);
      logic [24:0] sum;
      logic [24:0] dif;
      sum = 25'({l[23], l} + {r[23], r});
      dif = 25'({l[23], l} - {r[23], r});
      case (m)
         am_pass_through_pair: arrange = {l, r};
         am_swap_sides:        arrange = {r, l};
         am_left_to_both:      arrange = {l, l};
         am_right_to_both:     arrange = {r, r};
         am_invert_left:       arrange = {neg_sat(l), r};
         am_invert_right:      arrange = {l, neg_sat(r)};
         am_mono_sum:          arrange = {sum[24:1], sum[24:1]};
         am_mid_side:          arrange = {sum[24:1], dif[24:1]};
         default:              arrange = {l, r};
      endcase
   endfunction : arrange

   // ---------------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------------
   // R04 per-pair mode settings
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl_q <= `ATPE_CTRL_RST;
         emb_q  <= `ATPE_EMB_RST;
         mode_q <= `ATPE_MODE_RST;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            `ATPE_CTRL_OFS: ctrl_q <= reg_wdata[2:0];
            `ATPE_EMB_OFS:  emb_q <= reg_wdata[15:0];
            `ATPE_MODE_OFS: mode_q <= reg_wdata[23:0];
            default:        ;
         endcase
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (reg_addr)
         `ATPE_CTRL_OFS: rd_mux = {29'h0, ctrl_q};
         `ATPE_EMB_OFS:  rd_mux = {16'h0, emb_q};
         `ATPE_MODE_OFS: rd_mux = {8'h00, mode_q};
         `ATPE_STAT_OFS: rd_mux = {25'h0, idx_q, quad_q, tone_st_q == ts_gap};
         default: begin
            for (int p = 0; p < 8; p++) begin
               if (reg_addr == 8'(`ATPE_GAIN_OFS + 8'(p * 4))) begin
                  rd_mux = {16'h0, gain_vec[p*16 +: 16]};
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rdata <= 32'h00000000;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   // ---------------------------------------------------------------------
   // Tone generator
   // ---------------------------------------------------------------------
   // R02 gap timing state
   always_ff @(posedge clk) begin
      if (!nrst) begin
         gap_cnt_q <= 32'h00000000;
         tone_st_q <= ts_gap;
      end else if (ce) begin
         gap_cnt_q <= (gap_cnt_q == PERIOD_LAST) ? 32'h00000000 : gap_cnt_q + 32'h1;
         case (tone_st_q)
            ts_run:  if (gap_cnt_q == PERIOD_LAST) tone_st_q <= ts_gap;
            ts_gap:  if (gap_cnt_q == GAP_LAST) tone_st_q <= ts_run;
            default: tone_st_q <= ts_run;
         endcase
      end
   end

   // R01 48 steps per cycle at 48 kHz
   always_ff @(posedge clk) begin
      if (!nrst) begin
         quad_q <= 2'h0;
         idx_q  <= 4'h0;
      end else if (ce && smp_tick) begin
         if (idx_q == `ATPE_QSTEPS - 4'h1) begin
            idx_q  <= 4'h0;
            quad_q <= quad_q + 2'h1;
         end else begin
            idx_q <= idx_q + 4'h1;
         end
      end
   end

   // R03 level select
   always_comb begin
      lut_idx  = quad_q[0] ? `ATPE_QSTEPS - idx_q : idx_q;
      amp      = ctrl_q[`ATPE_CTRL_LVL20] ? `ATPE_AMP_20DB : `ATPE_AMP_18DB;
      tprod    = {33'h0, sine_q15(lut_idx)} * {24'h0, amp};
      tmag     = tprod[38:15];
      tone_val = quad_q[1] ? 24'(-tmag) : tmag;
   end

   // R02 left muted during gap
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tone_l_q <= 24'h000000;
         tone_r_q <= 24'h000000;
      end else if (ce && smp_tick) begin
         tone_l_q <= (tone_st_q == ts_gap) ? 24'h000000 : tone_val;
         tone_r_q <= tone_val;
      end
   end

   // ---------------------------------------------------------------------
   // Pair pipeline: arrange, gain, embed
   // ---------------------------------------------------------------------
   // R22 input taken on every strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         vld1_q    <= 1'b0;
         vld2_q    <= 1'b0;
         emb_vld_q <= 1'b0;
      end else if (ce) begin
         vld1_q    <= mx_vld;
         vld2_q    <= vld1_q;
         emb_vld_q <= vld2_q;
      end
   end

   // R21 eight pairs
   for (genvar p = 0; p < 8; p++) begin : g_pair
      localparam int G = p / 2;
      logic [15:0] gain_q;
      logic [23:0] al_q;
      logic [23:0] ar_q;
      logic [23:0] gl;
      logic [23:0] gr;
      logic [23:0] el_q;
      logic [23:0] er_q;
      logic        na1_q;
      logic        na2_q;
      logic        na3_q;
      logic        trunc;
      logic [47:0] arr;

      assign gain_vec[p*16 +: 16] = gain_q;
      assign arr = arrange(atpe_mode_t'(mode_q[p*3 +: 3]), mx_l[p*24 +: 24], mx_r[p*24 +: 24]);

      // R04 own gain per pair
      always_ff @(posedge clk) begin
         if (!nrst) begin
            gain_q <= `ATPE_GAIN_RST;
         end else if (ce && reg_wr && reg_addr == 8'(`ATPE_GAIN_OFS + 8'(p * 4))) begin
            gain_q <= reg_wdata[15:0];
         end
      end

      // R05 R06 R07 R08 R09 R10 R11 R12 R23 arrangement
      always_ff @(posedge clk) begin
         if (!nrst) begin
            al_q  <= 24'h000000;
            ar_q  <= 24'h000000;
            na1_q <= 1'b0;
         end else if (ce && mx_vld) begin
            al_q  <= arr[47:24];
            ar_q  <= arr[23:0];
            na1_q <= mx_non_audio[p];
         end
      end

      atpe_gain u_gain_l (
         .clk       (clk),
         .nrst      (nrst),
         .ce        (ce),
         .smp_vld   (vld1_q),
         .non_audio (na1_q),
         .gain_set  (gain_q),
         .smp_in    (al_q),
         .smp_q     (gl)
      );

      atpe_gain u_gain_r (
         .clk       (clk),
         .nrst      (nrst),
         .ce        (ce),
         .smp_vld   (vld1_q),
         .non_audio (na1_q),
         .gain_set  (gain_q),
         .smp_in    (ar_q),
         .smp_q     (gr)
      );

      // R17 SD truncation of audio words
      assign trunc = sd && emb_q[G*4 + `ATPE_EMB_TRUNC] && !na2_q;

      // R16 disabled group emptied
      always_ff @(posedge clk) begin
         if (!nrst) begin
            na2_q <= 1'b0;
            na3_q <= 1'b0;
            el_q  <= 24'h000000;
            er_q  <= 24'h000000;
         end else if (ce) begin
            if (vld1_q) na2_q <= na1_q;
            if (vld2_q) begin
               na3_q <= na2_q;
               el_q  <= 24'h000000;
               er_q  <= 24'h000000;
               if (!byp && emb_q[G*4 + `ATPE_EMB_EN]) begin
                  el_q <= trunc ? {gl[23:4], 4'h0} : gl;
                  er_q <= trunc ? {gr[23:4], 4'h0} : gr;
               end
            end
         end
      end

      assign emb_l_q[p*24 +: 24]  = el_q;
      assign emb_r_q[p*24 +: 24]  = er_q;
      assign emb_non_audio_q[p]   = na3_q;
   end

   // R18 R19 R20 group insert and packet control
   always_ff @(posedge clk) begin
      if (!nrst) begin
         grp_insert_q <= 4'h0;
         grp_remove_q <= 4'h0;
         acp_insert_q <= 4'h0;
         emb_bypass_q <= 1'b0;
      end else if (ce && vld2_q) begin
         emb_bypass_q <= byp;
         for (int g = 0; g < 4; g++) begin
            grp_insert_q[g] <= !byp && emb_q[g*4 + `ATPE_EMB_EN];
            grp_remove_q[g] <= !byp && !emb_q[g*4 + `ATPE_EMB_EN];
            acp_insert_q[g] <= !byp && emb_q[g*4 + `ATPE_EMB_EN]
                               && (!sd || emb_q[g*4 + `ATPE_EMB_ACP]);
         end
      end
   end

   // ---------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------
   property p_gap_left;
      @(posedge clk) disable iff (!nrst)
      ce && smp_tick && tone_st_q == ts_gap |=> tone_l_q == 24'h000000;
   endproperty
   a_gap_left: assert property (p_gap_left) // R02
      else $error("left tone not silent in gap");

   property p_right_cont;
      @(posedge clk) disable iff (!nrst)
      ce && smp_tick && tone_st_q == ts_run |=> tone_l_q == tone_r_q;
   endproperty
   a_right_cont: assert property (p_right_cont) // R02
      else $error("left and right tone differ outside gap");

   property p_tone_peak;
      @(posedge clk) disable iff (!nrst)
      ce && smp_tick && quad_q == 2'h1 && idx_q == 4'h0
      |=> tone_r_q <= $past(amp) && tone_r_q > $past(amp) - 24'h000040;
   endproperty
   a_tone_peak: assert property (p_tone_peak) // R03
      else $error("tone peak does not match level");

   property p_swap;
      @(posedge clk) disable iff (!nrst)
      ce && mx_vld && mode_q[5:3] == am_swap_sides |=> g_pair[1].al_q == $past(mx_r[47:24]);
   endproperty
   a_swap: assert property (p_swap) // R05
      else $error("swap mode left not from right");

   property p_mono;
      @(posedge clk) disable iff (!nrst)
      ce && mx_vld && mode_q[20:18] == am_mono_sum |=> g_pair[6].al_q == g_pair[6].ar_q;
   endproperty
   a_mono: assert property (p_mono) // R10
      else $error("mono sum outputs differ");

   property p_bypass;
      @(posedge clk) disable iff (!nrst)
      ce && vld2_q && byp |=> grp_insert_q == 4'h0 && acp_insert_q == 4'h0 && emb_bypass_q;
   endproperty
   a_bypass: assert property (p_bypass) // R20
      else $error("embedder active during bypass");

   property p_grp_off;
      @(posedge clk) disable iff (!nrst)
      ce && vld2_q && !byp && !emb_q[`ATPE_EMB_EN]
      |=> grp_remove_q[0] && g_pair[0].el_q == 24'h000000;
   endproperty
   a_grp_off: assert property (p_grp_off) // R16
      else $error("disabled group still carries audio");

   property p_trunc;
      @(posedge clk) disable iff (!nrst)
      ce && vld2_q && g_pair[2].trunc |=> g_pair[2].el_q[3:0] == 4'h0;
   endproperty
   a_trunc: assert property (p_trunc) // R17
      else $error("truncated sample keeps low bits");

   property p_read_idle;
      @(posedge clk) disable iff (!nrst)
      ce && !reg_rd |=> reg_rdata == 32'h00000000;
   endproperty
   a_read_idle: assert property (p_read_idle) // R04
      else $error("read data outside read answer cycle");
endmodule : atpe_top

// >>> src/atpe_regs.svh
// Offsets, field positions, reset values and timing counts of the audio path block.
// Included by the design modules atpe_top and atpe_gain; definitions only.
`ifndef ATPE_REGS_SVH
`define ATPE_REGS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ATPE_CTRL_OFS   8'h00
`define ATPE_EMB_OFS    8'h04
`define ATPE_MODE_OFS   8'h08
`define ATPE_STAT_OFS   8'h0C
`define ATPE_GAIN_OFS   8'h20
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATPE_CTRL_LVL20 0
`define ATPE_CTRL_SD    1
`define ATPE_CTRL_BYP   2
`define ATPE_EMB_EN     0
`define ATPE_EMB_ACP    1
`define ATPE_EMB_TRUNC  2
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ATPE_CTRL_RST   3'h0
`define ATPE_EMB_RST    16'h3333
`define ATPE_MODE_RST   24'h000000
`define ATPE_GAIN_RST   16'h0000
// ----------------------------------------------------------------
// Tone and timing
// ----------------------------------------------------------------
`define ATPE_CLK_KHZ    20000
`define ATPE_PERIOD_MS  3000
`define ATPE_GAP_MS     250
`define ATPE_QSTEPS     4'hC
`define ATPE_AMP_18DB   24'h101D3E
`define ATPE_AMP_20DB   24'h0CCCCD
// ----------------------------------------------------------------
// Gain and sample limits
// ----------------------------------------------------------------
`define ATPE_GAIN_MAX   16'h2580
`define ATPE_GAIN_MIN   16'hDA80
`define ATPE_LOG2_K     32'h00006CDA
`define ATPE_SMP_MAX    24'h7FFFFF
`define ATPE_SMP_MIN    24'h800000
`endif

// >>> src/atpe_pkg.sv
// Types shared by the audio path modules.
// Assumes nothing beyond the register header.
package atpe_pkg;
   typedef enum logic [2:0] {
      am_pass_through_pair = 3'h0,
      am_swap_sides        = 3'h1,
      am_left_to_both      = 3'h2,
      am_right_to_both     = 3'h3,
      am_invert_left       = 3'h4,
      am_invert_right      = 3'h5,
      am_mono_sum          = 3'h6,
      am_mid_side          = 3'h7
   } atpe_mode_t;

   typedef enum logic [1:0] {
      ts_run = 2'h0,
      ts_gap = 2'h1
   } atpe_tone_st_t;
endpackage : atpe_pkg

// >>> src/atpe_gain.sv
// One-channel gain stage: setting in hundredths of a dB, one cycle latency.
// Assumes smp_vld is a one-cycle strobe on clk.
`timescale 1ns/1ns
`include "atpe_regs.svh"
module atpe_gain
   import atpe_pkg::*;
(
   // Clock and control
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic               ce,
   // Sample in
   input  wire logic               smp_vld,
   input  wire logic               non_audio,
   input  wire logic signed [15:0] gain_set,
   input  wire logic signed [23:0] smp_in,
   // Sample out
   output logic signed [23:0]      smp_q
);
   logic signed [15:0] gclip;
   logic signed [31:0] lg2;
   logic signed [7:0]  shs;
   logic        [16:0] m_lo;
   logic        [16:0] m_hi;
   logic        [16:0] mant;
   logic signed [63:0] prod;
   logic signed [63:0] shd;
   logic signed [23:0] sat;

   function automatic logic [16:0] pow2_q14(input logic [4:0] k);
      case (k)
         5'h00:   pow2_q14 = 17'h04000;
         5'h01:   pow2_q14 = 17'h042D5;
         5'h02:   pow2_q14 = 17'h045CB;
         5'h03:   pow2_q14 = 17'h048E2;
         5'h04:   pow2_q14 = 17'h04C1C;
         5'h05:   pow2_q14 = 17'h04F7B;
         5'h06:   pow2_q14 = 17'h052FF;
         5'h07:   pow2_q14 = 17'h056AC;
         5'h08:   pow2_q14 = 17'h05A82;
         5'h09:   pow2_q14 = 17'h05E84;
         5'h0A:   pow2_q14 = 17'h062B4;
         5'h0B:   pow2_q14 = 17'h06712;
         5'h0C:   pow2_q14 = 17'h06BA2;
         5'h0D:   pow2_q14 = 17'h07066;
         5'h0E:   pow2_q14 = 17'h07560;
         5'h0F:   pow2_q14 = 17'h07A93;
         default: pow2_q14 = 17'h08000;
      endcase
   endfunction : pow2_q14

   // R14 setting clamped to range
   always_comb begin
      gclip = gain_set;
      if (gain_set > $signed(`ATPE_GAIN_MAX)) gclip = $signed(`ATPE_GAIN_MAX);
      if (gain_set < $signed(`ATPE_GAIN_MIN)) gclip = $signed(`ATPE_GAIN_MIN);
   end

   // R13 dB to linear mantissa
   always_comb begin
      lg2  = (32'(gclip) * $signed(`ATPE_LOG2_K)) >>> 16;
      shs  = 8'sd15 - $signed(lg2[15:8]);
      m_lo = pow2_q14({1'b0, lg2[7:4]});
      m_hi = pow2_q14(5'({1'b0, lg2[7:4]} + 5'h01));
      mant = m_lo + 17'(((m_hi - m_lo) * {13'h0000, lg2[3:0]}) >> 4);
   end

   // R24 round to nearest, saturate
   always_comb begin
      prod = (64'(smp_in) * $signed({47'h0, mant})) <<< 1;
      if (shs[4:0] != 5'h00) prod = prod + (64'sd1 <<< (shs[4:0] - 5'h01));
      shd = prod >>> shs[4:0];
      sat = shd[23:0];
      if (shd > $signed(64'(`ATPE_SMP_MAX))) sat = `ATPE_SMP_MAX;
      if (shd < -$signed(64'h800000)) sat = `ATPE_SMP_MIN;
   end

   // R15 data words pass bit-exact
   always_ff @(posedge clk) begin
      if (!nrst) begin
         smp_q <= 24'h000000;
      end else if (ce && smp_vld) begin
         smp_q <= non_audio ? smp_in : sat;
      end
   end

   property p_gain_bypass;
      @(posedge clk) disable iff (!nrst)
      ce && smp_vld && non_audio |=> smp_q == $past(smp_in);
   endproperty
   a_gain_bypass: assert property (p_gain_bypass) // R15
      else $error("non-audio sample altered by gain");

   property p_gain_unity;
      @(posedge clk) disable iff (!nrst)
      ce && smp_vld && !non_audio && gain_set == 16'h0000 |=> smp_q == $past(smp_in);
   endproperty
   a_gain_unity: assert property (p_gain_unity) // R13
      else $error("zero dB setting changed the sample");
endmodule : atpe_gain

// >>> sim/atpe_mx_model.sv
// Cross-point matrix model: presents one set of pairs per request.
// Assumes go is a one-cycle request from the bench on clk.
`timescale 1ns/1ns
module atpe_mx_model (
   // Clock and request
   input  wire logic         clk,
   input  wire logic         go,
   input  wire logic [191:0] l_in,
   input  wire logic [191:0] r_in,
   input  wire logic [7:0]   na_in,
   // Pairs out
   output logic              mx_vld,
   output logic      [191:0] mx_l,
   output logic      [191:0] mx_r,
   output logic      [7:0]   mx_non_audio
);
   initial begin
      mx_vld = 1'b0;
      mx_l = '0;
      mx_r = '0;
      mx_non_audio = 8'h00;
   end
   // One-cycle strobe; stale data inverted afterwards
   always @(posedge clk) begin
      mx_vld <= go;
      mx_l <= go ? l_in : ~mx_l;
      mx_r <= go ? r_in : ~mx_r;
      mx_non_audio <= go ? na_in : ~mx_non_audio;
   end
endmodule : atpe_mx_model

// >>> sim/testbench.sv
// Self-checking bench for the audio path block.
// Assumes a 20 MHz clock and shortened tone period parameters.
`timescale 1ns/1ns
module testbench;
   logic clk = 0, nrst = 0, tick = 0, go = 0, wr = 0, rd = 0, ce = 1, mv, ev, byp;
   logic [7:0] addr = 8'h00, na = 8'h00, mna, ena;
   logic [31:0] wd = 32'h0, rdata;
   logic [191:0] li = '0, ri = '0, ml, mr, el, er, xl, xr;
   logic [23:0] tl, tr;
   logic [3:0] ins, rem, acp;
   int fails = 0, total_checks = 0;
   always #25 clk = ~clk;
   atpe_mx_model i_mx (.clk(clk), .go(go), .l_in(li), .r_in(ri), .na_in(na),
      .mx_vld(mv), .mx_l(ml), .mx_r(mr), .mx_non_audio(mna));
   atpe_top #(.TONE_PERIOD_CYC(120), .TONE_GAP_CYC(10)) i_dut (.clk(clk), .nrst(nrst),
      .ce(ce), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .smp_tick(tick), .tone_l_q(tl), .tone_r_q(tr), .mx_vld(mv),
      .mx_l(ml), .mx_r(mr), .mx_non_audio(mna), .emb_vld_q(ev), .emb_l_q(el),
      .emb_r_q(er), .emb_non_audio_q(ena), .grp_insert_q(ins), .grp_remove_q(rem),
      .acp_insert_q(acp), .emb_bypass_q(byp));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [191:0] s, input logic [191:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : rreg
   task automatic send(input logic [23:0] l, input logic [23:0] r, input logic [7:0] n);
      int i;
      @(posedge clk);
      li <= {8{l}};
      ri <= {8{r}};
      na <= n;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (i = 0; i < 10 && ev !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(i, 3);
   endtask : send
   task automatic print_verdict;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_tone;
      int gap, bad, pk, lv;
      for (lv = 0; lv < 2; lv++) begin
         gap = 0;
         bad = 0;
         pk = 0;
         wreg(8'h00, lv);
         for (int c = 0; c < 120; c++) begin
            @(posedge clk);
            tick <= 1'b1;
            #1;
            if (tl === 24'h0 && tr !== 24'h0) gap++;
            if (tl !== 24'h0 && tl !== tr) bad++;
            if ($signed(tr) > pk) pk = $signed(tr);
         end
         @(posedge clk);
         ce <= 1'b0;
         #1 xl[23:0] = tr;
         repeat (4) @(posedge clk);
         tick <= 1'b0;
         ce <= 1'b1;
         #1 chk(tr, xl[23:0]);
         chk(gap >= 8 && gap <= 11, 1);
         chk(bad, 0);
         chk(pk + 64 >= (lv ? 24'h0CCCCD : 24'h101D3E) && pk <= (lv ? 24'h0CCCCD : 24'h101D3E), 1);
      end
      $display("tone test done");
   endtask : t_tone
   task automatic t_regs;
      rreg(8'h04, 32'h3333);
      rreg(8'h00, 32'h1);
      wreg(8'h10, 32'hFFFF);
      rreg(8'h10, 32'h0);
      wreg(8'h24, 32'h7FFF);
      wreg(8'h28, 32'h8000);
      wreg(8'h20, 32'h2580);
      rreg(8'h24, 32'h7FFF);
      rreg(8'h28, 32'h8000);
      $display("register test done");
   endtask : t_regs
   task automatic t_gain;
      send(24'h000100, 24'h000090, 8'h02);
      chk(el, {{5{24'h000100}}, 24'h000000, 24'h000100, 24'h7FFFFF});
      chk(er, {{5{24'h000090}}, 24'h000000, 24'h000090, 24'h7FFFFF});
      chk(ena, 8'h02);
      $display("gain test done");
   endtask : t_gain
   task automatic t_modes;
      for (int p = 0; p < 3; p++) wreg(8'h20 + 8'(4 * p), 32'h0);
      wreg(8'h08, 32'hFAC688);
      send(24'h000100, 24'h000040, 8'h00);
      xl = {24'hA0, 24'hA0, 24'h100, 24'hFFFF00, 24'h40, 24'h100, 24'h40, 24'h100};
      xr = {24'h60, 24'hA0, 24'hFFFFC0, 24'h40, 24'h40, 24'h100, 24'h100, 24'h40};
      chk(el, xl);
      chk(er, xr);
      $display("mode test done");
   endtask : t_modes
   task automatic t_embed;
      wreg(8'h08, 32'h0);
      wreg(8'h04, 32'h5070);
      wreg(8'h00, 32'h2);
      send(24'h00010F, 24'h000047, 8'h00);
      chk(el, {{2{24'h000100}}, 48'h0, {2{24'h000100}}, 48'h0});
      chk({ins, rem, acp}, 12'hA52);
      wreg(8'h00, 32'h0);
      send(24'h00010F, 24'h000047, 8'h00);
      chk(er, {{2{24'h000047}}, 48'h0, {2{24'h000047}}, 48'h0});
      chk({ins, rem, acp}, 12'hA5A);
      wreg(8'h00, 32'h4);
      send(24'h00010F, 24'h000047, 8'h00);
      chk({byp, ins, rem, el[71:48]}, 33'h100000000);
      $display("embed test done");
   endtask : t_embed
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_tone();
      t_regs();
      t_gain();
      t_modes();
      t_embed();
      print_verdict();
   end
   initial begin
      #2000000;
      fails++;
      print_verdict();
   end
endmodule : testbench
